// [scbp_pkg.sv]
// Package with register map, field layout and constants of the serial channel buffer port.
`default_nettype none
package scbp_pkg;
  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] OFS_BUFFER_WINDOW = 8'h00;
  localparam logic [7:0] OFS_RX_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_QUIET_FILL_PATTERN = 8'h08;
  localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_TX_ASSERT = 8'h10;
  localparam logic [7:0] OFS_TX_DEASSERT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_COUNTS = 8'h1C;
  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int THR_W = 5;
  localparam int DEPTH = 32;
  localparam int AW = 5;
  localparam int CW = 6;
  localparam int CTL_FILL_SELECT_BIT = 0;
  localparam int CTL_SYNC_MODE_BIT = 1;
  localparam int CTL_CPU_MODE_LSB = 2;
  localparam int CTL_TX_RESET_BIT = 4;
  localparam int CTL_RX_RESET_BIT = 5;
  localparam int ST_RX_READY_BIT = 0;
  localparam int ST_TX_READY_BIT = 1;
  localparam int ST_STAGE0_BIT = 2;
  localparam int ST_STAGE1_BIT = 3;
  localparam int ST_TX_IDLE_BIT = 4;
  localparam int ST_TX_LOST_BIT = 5;
  localparam logic [7:0] RST_QUIET_FILL_PATTERN = 8'h7E;
  localparam logic [4:0] RST_RX_THRESHOLD = 5'h00;
  localparam logic [4:0] RST_TX_ASSERT = 5'h10;
  localparam logic [4:0] RST_TX_DEASSERT = 5'h1E;
  localparam logic [1:0] CPU_MODE_0 = 2'h0;
  localparam logic [1:0] CPU_MODE_1 = 2'h1;
  // Bit period of the transmit line, in pclk cycles.
  localparam logic [7:0] TX_BIT_CYCLES = 8'h08;
  typedef enum logic [2:0] {
    SCBP_TX_IDLE = 3'b001,
    SCBP_TX_LOAD = 3'b010,
    SCBP_TX_SHIFT = 3'b100
  } scbp_tx_state_t;
endpackage : scbp_pkg
`default_nettype wire

// [scbp_byte_queue.sv]
// Byte queue of 32 stages with occupancy count, used for both directions.
`default_nettype none
module scbp_byte_queue
  import scbp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic push1,
  input wire logic push2,
  input wire logic [7:0] push_a,
  input wire logic [7:0] push_b,
  input wire logic pop1,
  input wire logic pop2,
  output logic [7:0] head0,
  output logic [7:0] head1,
  output logic [CW-1:0] count
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] n_in;
  logic [CW-1:0] n_out;

  assign n_in = push2 ? CW'(2) : (push1 ? CW'(1) : CW'(0));
  assign n_out = pop2 ? CW'(2) : (pop1 ? CW'(1) : CW'(0));
  // Oldest entry first keeps arrival order on both sides.
  assign head0 = mem[rd_reg];
  assign head1 = mem[AW'(rd_reg + AW'(1))];
  assign count = cnt_reg;

  always_ff @(posedge pclk) begin
    if (push1 || push2) begin
      mem[wr_reg] <= push_a;
    end
    if (push2) begin
      mem[AW'(wr_reg + AW'(1))] <= push_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= AW'(wr_reg + n_in[AW-1:0]);
      rd_reg <= AW'(rd_reg + n_out[AW-1:0]);
      cnt_reg <= CW'(cnt_reg + n_in - n_out);
    end
  end
endmodule : scbp_byte_queue
`default_nettype wire

// [scbp_tx_line.sv]
// Transmit line serialiser with idle fill pattern or mark level.
`default_nettype none
module scbp_tx_line
  import scbp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_mode,
  input wire logic fill_select,
  input wire logic [7:0] fill_pattern,
  input wire logic data_avail,
  input wire logic [7:0] data_byte,
  output logic data_take,
  output logic idle,
  output logic txd
);
  scbp_tx_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tick_reg;
  logic [2:0] bit_reg;
  logic fill_reg;
  logic txd_reg;
  logic tick;

  assign tick = (tick_reg == TX_BIT_CYCLES - 8'h01);
  assign data_take = (state_reg == SCBP_TX_LOAD);
  assign idle = (state_reg == SCBP_TX_IDLE);
  assign txd = txd_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 8'h00;
    end else begin
      tick_reg <= tick ? 8'h00 : 8'(tick_reg + 8'h01);
    end
  end

  // Idle fill is shifted byte by byte, so a frame only starts at a byte edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SCBP_TX_IDLE;
      shift_reg <= 8'hFF;
      bit_reg <= 3'h0;
      fill_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else begin
      case (state_reg)
        SCBP_TX_IDLE: begin
          if (tick) begin
            if (bit_reg == 3'h0 && data_avail) begin
              state_reg <= SCBP_TX_LOAD;
            end else begin
              if (bit_reg == 3'h0) begin
                fill_reg <= sync_mode && fill_select;
                shift_reg <= fill_pattern;
              end
              // Pattern repeats during idle; otherwise line held high.
              txd_reg <= (bit_reg == 3'h0) ? ((sync_mode && fill_select) ? fill_pattern[0] : 1'b1)
                                          : (fill_reg ? shift_reg[bit_reg] : 1'b1);
              bit_reg <= 3'(bit_reg + 3'h1);
            end
          end
        end
        SCBP_TX_LOAD: begin
          shift_reg <= data_byte;
          bit_reg <= 3'h0;
          state_reg <= SCBP_TX_SHIFT;
        end
        SCBP_TX_SHIFT: begin
          if (tick) begin
            txd_reg <= shift_reg[bit_reg];
            bit_reg <= 3'(bit_reg + 3'h1);
            if (bit_reg == 3'h7) begin
              state_reg <= data_avail ? SCBP_TX_LOAD : SCBP_TX_IDLE;
            end
          end
        end
        default: begin
          state_reg <= SCBP_TX_IDLE;
        end
      endcase
    end
  end
endmodule : scbp_tx_line
`default_nettype wire

// [scbp_channel.sv]
// Top of the serial channel buffer port: APB slave, receive and transmit queues, flags.
//
// Summary of operation
// - Synchronous idle with select set repeats fill pattern.
// - Select clear holds transmit line high when idle.
// - One window reads receive, writes transmit buffer.
// - Mode 0 word read: first byte low lane.
// - Mode 1 byte reads only, oldest byte.
// - Modes 2,3 word read: first byte high lane.
// - Word moves two entries, byte moves one.
// - Receive buffer keeps arrival order.
// - DMA never takes an undefined window byte.
// - Mode 0 word write queues low lane first.
// - Mode 1 byte writes only, one byte each.
// - Modes 2,3 word write queues high lane first.
// - Transmit buffer sends bytes in queued order.
// - Write to full transmit buffer is discarded.
// - Receive ready set at count threshold plus one.
// - Receive ready cleared only when buffer empty.
// - Upper three threshold bits read zero.
// - Transmit ready hysteresis between two thresholds.
// - Stage presence flags for first two stages.
//
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module scbp_channel
  import scbp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_overrun,
  input wire logic dma_rx_req,
  input wire logic dma_tx_req,
  input wire logic dma_word,
  input wire logic [15:0] dma_wdata,
  output logic [15:0] dma_rdata,
  output logic dma_ack,
  output logic rx_ready_flag,
  output logic tx_ready_flag,
  output logic txd
);
  import scbp_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Byte count an access touches on the window: word is two, a lane is one.
  function automatic logic [1:0] lane_count(input logic [3:0] strb);
    if (strb[1:0] == 2'b11) begin
      lane_count = 2'h2;
    end else if (strb[1] || strb[0]) begin
      lane_count = 2'h1;
    end else begin
      lane_count = 2'h0;
    end
  endfunction : lane_count

  // Places first/second byte on lanes per CPU mode; second lane is high in mode 0.
  function automatic logic [15:0] lane_place(input logic [1:0] mode, input logic [7:0] first,
                                             input logic [7:0] second);
    if (mode == CPU_MODE_0) begin
      lane_place = {second, first};
    end else begin
      lane_place = {first, second};
    end
  endfunction : lane_place

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [7:0] quiet_fill_pattern_reg;
  logic [4:0] rx_threshold_field_reg;
  logic [4:0] tx_assert_value_reg;
  logic [4:0] tx_deassert_field_reg;
  logic [5:0] channel_control_reg;
  logic rx_ready_reg;
  logic tx_ready_reg;
  logic tx_lost_reg;
  logic rx_overrun_reg;
  logic [31:0] prdata_reg;
  logic [15:0] dma_rdata_reg;
  logic dma_ack_reg;
  logic rx_v1_reg;
  logic rx_v2_reg;
  logic [7:0] rx_d1_reg;
  logic [7:0] rx_d2_reg;
  logic rx_v_seen_reg;

  logic [1:0] cpu_mode;
  logic access;
  logic win_hit;
  logic [1:0] host_n;
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;
  logic [CW-1:0] tx_free;
  logic [7:0] rx_h0;
  logic [7:0] rx_h1;
  logic [7:0] tx_h0;
  logic rx_push;
  logic rx_pop1;
  logic rx_pop2;
  logic tx_push1;
  logic tx_push2;
  logic [7:0] tx_a;
  logic [7:0] tx_b;
  logic tx_take;
  logic tx_idle;
  logic dma_rx_go;
  logic dma_tx_go;
  logic host_rd;
  logic host_wr;
  logic [1:0] host_rd_n;
  logic [1:0] host_wr_n;

  assign cpu_mode = channel_control_reg[CTL_CPU_MODE_LSB +: 2];
  assign access = psel && penable;
  assign win_hit = (paddr == OFS_BUFFER_WINDOW);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_reg;
  assign rx_ready_flag = rx_ready_reg;
  assign tx_ready_flag = tx_ready_reg;
  assign rx_overrun = rx_overrun_reg;
  assign dma_rdata = dma_rdata_reg;
  assign dma_ack = dma_ack_reg;
  assign tx_free = CW'(DEPTH) - tx_count;

  // Mode 1 has no word access, so a word strobe counts as one lane.
  assign host_n = (cpu_mode == CPU_MODE_1 && lane_count(pstrb) == 2'h2) ? 2'h1
                                                                         : lane_count(pstrb);
  assign host_rd = access && !pwrite && win_hit && host_n != 2'h0;
  assign host_wr = access && pwrite && win_hit && host_n != 2'h0;

  // ****************************************************************
  // Receive side
  // ****************************************************************
  // Serial input arrives from another domain and is synchronised first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_v1_reg <= 1'b0;
      rx_v2_reg <= 1'b0;
      rx_d1_reg <= 8'h00;
      rx_d2_reg <= 8'h00;
      rx_v_seen_reg <= 1'b0;
    end else begin
      rx_v1_reg <= rx_valid;
      rx_v2_reg <= rx_v1_reg;
      rx_d1_reg <= rx_byte;
      rx_d2_reg <= rx_d1_reg;
      rx_v_seen_reg <= rx_v2_reg;
    end
  end

  // DMA only pops when enough data is present, so undefined bytes never leave.
  // Any host window access wins the cycle, so DMA never interleaves with it.
  assign dma_rx_go = dma_rx_req && !(access && win_hit) &&
                     rx_count >= (dma_word ? CW'(2) : CW'(1));
  assign host_rd_n = (CW'(host_n) > rx_count) ? 2'(rx_count) : host_n;
  assign rx_pop2 = (host_rd && host_rd_n == 2'h2) || (dma_rx_go && dma_word);
  assign rx_pop1 = (host_rd && host_rd_n == 2'h1) || (dma_rx_go && !dma_word);
  assign rx_push = rx_v2_reg && !rx_v_seen_reg && (rx_count < CW'(DEPTH) || rx_pop1 || rx_pop2);

  scbp_byte_queue u_rx_queue (
    .pclk(pclk),
    .presetn(presetn),
    .flush(channel_control_reg[CTL_RX_RESET_BIT]),
    .push1(rx_push),
    .push2(1'b0),
    .push_a(rx_d2_reg),
    .push_b(8'h00),
    .pop1(rx_pop1),
    .pop2(rx_pop2),
    .head0(rx_h0),
    .head1(rx_h1),
    .count(rx_count)
  );

  // Set from count threshold, clear only when empty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready_reg <= 1'b0;
    end else if (rx_count == '0) begin
      rx_ready_reg <= 1'b0;
    end else if (rx_count >= CW'(rx_threshold_field_reg) + CW'(1)) begin
      rx_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overrun_reg <= 1'b0;
    end else if (rx_v2_reg && !rx_v_seen_reg && !rx_push) begin
      rx_overrun_reg <= 1'b1;
    end else if (access && pwrite && paddr == OFS_STATUS) begin
      rx_overrun_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  assign dma_tx_go = dma_tx_req && !(access && win_hit) &&
                     tx_free >= (dma_word ? CW'(2) : CW'(1));
  // Host writes beyond free space are dropped; queued bytes are kept.
  assign host_wr_n = (CW'(host_n) > tx_free) ? 2'h0 : host_n;
  assign tx_push2 = (host_wr && host_wr_n == 2'h2) || (dma_tx_go && dma_word);
  assign tx_push1 = (host_wr && host_wr_n == 2'h1) || (dma_tx_go && !dma_word);

  always_comb begin
    if (host_wr) begin
      if (host_wr_n == 2'h2) begin
        // Mode 0 sends low lane first, modes 2 and 3 high lane first.
        tx_a = (cpu_mode == CPU_MODE_0) ? pwdata[7:0] : pwdata[15:8];
        tx_b = (cpu_mode == CPU_MODE_0) ? pwdata[15:8] : pwdata[7:0];
      end else begin
        tx_a = pstrb[0] ? pwdata[7:0] : pwdata[15:8];
        tx_b = 8'h00;
      end
    end else begin
      // DMA words follow the host lane order of the current CPU mode.
      tx_a = (dma_word && cpu_mode != CPU_MODE_0) ? dma_wdata[15:8] : dma_wdata[7:0];
      tx_b = (cpu_mode == CPU_MODE_0) ? dma_wdata[15:8] : dma_wdata[7:0];
    end
  end

  scbp_byte_queue u_tx_queue (
    .pclk(pclk),
    .presetn(presetn),
    .flush(channel_control_reg[CTL_TX_RESET_BIT]),
    .push1(tx_push1),
    .push2(tx_push2),
    .push_a(tx_a),
    .push_b(tx_b),
    .pop1(tx_take),
    .pop2(1'b0),
    .head0(tx_h0),
    .head1(),
    .count(tx_count)
  );

  scbp_tx_line u_tx_line (
    .pclk(pclk),
    .presetn(presetn),
    .sync_mode(channel_control_reg[CTL_SYNC_MODE_BIT]),
    .fill_select(channel_control_reg[CTL_FILL_SELECT_BIT]),
    .fill_pattern(quiet_fill_pattern_reg),
    .data_avail(tx_count != '0),
    .data_byte(tx_h0),
    .data_take(tx_take),
    .idle(tx_idle),
    .txd(txd)
  );

  // Hysteresis: on at or below assert level, off above deassert level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready_reg <= 1'b1;
    end else if (tx_count <= CW'(tx_assert_value_reg)) begin
      tx_ready_reg <= 1'b1;
    end else if (tx_count >= CW'(tx_deassert_field_reg) + CW'(1)) begin
      tx_ready_reg <= 1'b0;
    end
  end

  // Sticky record of a discarded host write; the set wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_lost_reg <= 1'b0;
    end else if (host_wr && host_wr_n == 2'h0) begin
      tx_lost_reg <= 1'b1;
    end else if (access && pwrite && paddr == OFS_STATUS && pwdata[ST_TX_LOST_BIT]) begin
      tx_lost_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_fill_pattern_reg <= RST_QUIET_FILL_PATTERN;
      rx_threshold_field_reg <= RST_RX_THRESHOLD;
      tx_assert_value_reg <= RST_TX_ASSERT;
      tx_deassert_field_reg <= RST_TX_DEASSERT;
      channel_control_reg <= 6'h00;
    end else begin
      // Queue reset bits self-clear after one cycle.
      channel_control_reg[CTL_RX_RESET_BIT] <= 1'b0;
      channel_control_reg[CTL_TX_RESET_BIT] <= 1'b0;
      if (access && pwrite && pstrb[0]) begin
        case (paddr)
          OFS_QUIET_FILL_PATTERN: quiet_fill_pattern_reg <= pwdata[7:0];
          OFS_RX_THRESHOLD: rx_threshold_field_reg <= pwdata[THR_W-1:0];
          OFS_TX_ASSERT: tx_assert_value_reg <= pwdata[THR_W-1:0];
          OFS_TX_DEASSERT: tx_deassert_field_reg <= pwdata[THR_W-1:0];
          OFS_CHANNEL_CONTROL: channel_control_reg <= pwdata[5:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Read data and DMA answer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        // Window returns receive data; a word read with only one byte queued reads zero on the second lane.
        OFS_BUFFER_WINDOW: begin
          if (cpu_mode == CPU_MODE_1 || lane_count(pstrb) != 2'h2) begin
            prdata_reg <= {16'h0000, rx_h0, rx_h0};
          end else if (rx_count >= CW'(2)) begin
            prdata_reg <= {16'h0000, lane_place(cpu_mode, rx_h0, rx_h1)};
          end else begin
            prdata_reg <= {16'h0000, lane_place(cpu_mode, rx_h0, 8'h00)};
          end
        end
        OFS_RX_THRESHOLD: prdata_reg <= {27'h0, rx_threshold_field_reg};
        OFS_QUIET_FILL_PATTERN: prdata_reg <= {24'h0, quiet_fill_pattern_reg};
        OFS_CHANNEL_CONTROL: prdata_reg <= {26'h0, channel_control_reg};
        OFS_TX_ASSERT: prdata_reg <= {27'h0, tx_assert_value_reg};
        OFS_TX_DEASSERT: prdata_reg <= {27'h0, tx_deassert_field_reg};
        OFS_STATUS: prdata_reg <= {26'h0, tx_lost_reg, tx_idle, rx_count >= CW'(2),
                                   rx_count != '0, tx_ready_reg, rx_ready_reg};
        OFS_COUNTS: prdata_reg <= {18'h0, tx_count, 2'h0, rx_count};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_rdata_reg <= 16'h0000;
      dma_ack_reg <= 1'b0;
    end else begin
      dma_ack_reg <= dma_rx_go || dma_tx_go;
      if (dma_rx_go) begin
        dma_rdata_reg <= dma_word ? lane_place(cpu_mode, rx_h0, rx_h1) : {rx_h0, rx_h0};
      end
    end
  end
endmodule : scbp_channel
`default_nettype wire

// [scbp_channel_properties.sv]
// Concurrent checks on the ports of the serial channel buffer port.
`default_nettype none
module scbp_channel_properties
  import scbp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_overrun,
  input wire logic dma_rx_req,
  input wire logic dma_tx_req,
  input wire logic dma_ack,
  input wire logic rx_ready_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic win = acc && (paddr == OFS_BUFFER_WINDOW);
  wire logic ctl = acc && pwrite && (paddr == OFS_CHANNEL_CONTROL);
  wire logic stw = acc && pwrite && (paddr == OFS_STATUS);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_noerr; !pslverr; endproperty
  a_noerr: assert property (p_noerr) else $error("pslverr high");
  property p_ack; dma_ack |-> $past(dma_rx_req || dma_tx_req); endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_host; win |=> !dma_ack; endproperty
  a_host: assert property (p_host) else $error("dma granted on host cycle");
  // A flag may only drop two edges after a pop, or three after a flush write.
  property p_rxfall;
    $fell(rx_ready_flag) |-> $past(win && !pwrite, 2) || $past(dma_rx_req, 2) ||
      $past(ctl, 3);
  endproperty
  a_rxfall: assert property (p_rxfall) else $error("ready fell early");
  property p_ovr; rx_overrun && !stw |=> rx_overrun; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost");
  property p_ovrrdy; $rose(rx_overrun) |-> rx_ready_flag; endproperty
  a_ovrrdy: assert property (p_ovrrdy) else $error("full but not ready");
  property p_hold; !$stable(prdata) |-> $past(psel && !penable); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : scbp_channel_properties
`default_nettype wire

// [scbp_serial_model.sv]
// Serial unit model that delivers received bytes to the channel.
`default_nettype none
module scbp_serial_model (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hA5;
  end
  // ****************
  // Delivery
  // ****************
  // The byte line shows the inverse once the strobe drops, so stale data is never reused.
  task automatic send(input logic [7:0] x);
    rx_byte <= x;
    rx_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    rx_valid <= 1'b0;
    rx_byte <= ~x;
    repeat (4) @(posedge pclk);
  endtask : send
endmodule : scbp_serial_model
`default_nettype wire

// [tb_scbp_channel.sv]
// Self-checking bench of the serial channel buffer port.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_scbp_channel
  import scbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, rx_byte, a, b;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, rx_valid, rx_overrun, dma_ack, rx_ready_flag, tx_ready_flag, txd;
  logic dma_rx_req = 1'b0, dma_word = 1'b0;
  logic [15:0] dma_rdata, e, v;
  logic [1:0] mode = 2'h0;
  logic [7:0] rxq[$];
  int err_count = 0, samples_checked = 0, n;
  scbp_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_overrun(rx_overrun), .dma_rx_req(dma_rx_req), .dma_tx_req(1'b0),
    .dma_word(dma_word), .dma_wdata(16'h0000), .dma_rdata(dma_rdata), .dma_ack(dma_ack),
    .rx_ready_flag(rx_ready_flag), .tx_ready_flag(tx_ready_flag), .txd(txd));
  scbp_serial_model sm (.pclk(pclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  initial forever #4 pclk = ~pclk;
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // ****************
  // Tasks
  // ****************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // An idle edge follows each transfer so the strobes never change twice in one step.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, OFS_CHANNEL_CONTROL, d, 4'hF);
  endtask : ctl
  task automatic put(input logic [7:0] x);
    sm.send(x);
    if (rxq.size() < DEPTH) rxq.push_back(x);
    repeat (4) @(posedge pclk);
  endtask : put
  task automatic rd_win(input logic [3:0] s);
    apb(1'b0, OFS_BUFFER_WINDOW, 32'h0, s);
    a = rxq.pop_front();
    b = (s == 4'h3 && mode != CPU_MODE_1 && rxq.size() > 0) ? rxq.pop_front() : 8'h00;
    e = (s != 4'h3 || mode == CPU_MODE_1) ? {a, a} : (mode == CPU_MODE_0) ? {b, a} : {a, b};
    `CHK(r[15:0], e)
  endtask : rd_win
  task automatic dec();
    n = 0;
    while (txd !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      v[i] = txd;
      repeat (8) @(posedge pclk);
    end
  endtask : dec
  task automatic zc();
    n = 0;
    repeat (512) begin
      @(posedge pclk);
      n += (txd !== 1'b1);
    end
  endtask : zc
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(76));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0, 4'hF);
    `CHK(r, 32'h0)
    apb(1'b0, OFS_TX_DEASSERT, 32'h0, 4'hF);
    `CHK(r[4:0], RST_TX_DEASSERT)
    apb(1'b1, OFS_RX_THRESHOLD, 32'hFF, 4'hF);
    apb(1'b0, OFS_RX_THRESHOLD, 32'h0, 4'hF);
    `CHK(r, 32'h1F)
    apb(1'b1, OFS_RX_THRESHOLD, 32'h2, 4'hF);
    ctl(32'h2);
    for (int i = 0; i < 3; i++) begin
      `CHK(rx_ready_flag, 1'b0)
      put(8'($urandom));
    end
    `CHK(rx_ready_flag, 1'b1)
    rd_win(4'h3);
    `CHK(rx_ready_flag, 1'b1)
    rd_win(4'h3);
    @(posedge pclk);
    `CHK(rx_ready_flag, 1'b0)
    apb(1'b1, OFS_RX_THRESHOLD, 32'h0, 4'hF);
    for (int m = 1; m < 4; m++) begin
      mode = 2'(m);
      ctl(32'(m * 4 + 2));
      put(8'($urandom));
      put(8'($urandom));
      rd_win((m == 1) ? 4'h2 : 4'h3);
      if (m == 1) rd_win(4'h1);
      apb(1'b0, OFS_COUNTS, 32'h0, 4'hF);
      `CHK(r[5:0], 6'(rxq.size()))
    end
    mode = CPU_MODE_0;
    ctl(32'h2);
    put(8'($urandom));
    dma_word <= 1'b1;
    dma_rx_req <= 1'b1;
    repeat (8) begin
      @(posedge pclk);
      `CHK(dma_ack, 1'b0)
    end
    dma_rx_req <= 1'b0;
    put(8'($urandom));
    dma_rx_req <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (dma_ack !== 1'b1 && n < 50);
    dma_rx_req <= 1'b0;
    `CHK(dma_rdata, {rxq[1], rxq[0]})
    rxq.delete();
    for (int i = 0; i < 33; i++) put(8'($urandom));
    `CHK(rx_overrun, 1'b1)
    apb(1'b0, OFS_COUNTS, 32'h0, 4'hF);
    `CHK(r[5:0], 6'h20)
    apb(1'b1, OFS_STATUS, 32'h0, 4'hF);
    `CHK(rx_overrun, 1'b0)
    ctl(32'h22);
    rxq.delete();
    // Flush empties the queue one edge late and the flag follows one edge after.
    repeat (2) @(posedge pclk);
    `CHK(rx_ready_flag, 1'b0)
    for (int m = 0; m < 3; m++) begin
      ctl(32'(m * 4 + 2));
      a = 8'($urandom) & 8'hFE;
      b = 8'($urandom) & 8'hFE;
      fork
        dec();
        if (m == 1) begin
          apb(1'b1, OFS_BUFFER_WINDOW, {16'h0, b, a}, 4'h1);
          apb(1'b1, OFS_BUFFER_WINDOW, {16'h0, b, a}, 4'h2);
        end else apb(1'b1, OFS_BUFFER_WINDOW, {16'h0, b, a}, 4'h3);
      join
      `CHK(v, (m == 2) ? {a, b} : {b, a})
      repeat (100) @(posedge pclk);
    end
    ctl(32'h2);
    for (int i = 0; i < 20; i++) apb(1'b1, OFS_BUFFER_WINDOW, $urandom, 4'h3);
    `CHK(tx_ready_flag, 1'b0)
    apb(1'b0, OFS_STATUS, 32'h0, 4'hF);
    `CHK(r[ST_TX_LOST_BIT], 1'b1)
    ctl(32'h12);
    apb(1'b0, OFS_COUNTS, 32'h0, 4'hF);
    `CHK(r[13:8], 6'h00)
    `CHK(tx_ready_flag, 1'b1)
    // A byte already on the line when the flush hit still finishes first.
    repeat (100) @(posedge pclk);
    zc();
    `CHK(n, 0)
    a = 8'($urandom);
    apb(1'b1, OFS_QUIET_FILL_PATTERN, {24'h0, a}, 4'hF);
    ctl(32'h3);
    repeat (200) @(posedge pclk);
    zc();
    `CHK(n, 64 * (8 - $countones(a)))
    tally_and_finish();
  end
endmodule : tb_scbp_channel
bind scbp_channel scbp_channel_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_overrun(rx_overrun), .dma_rx_req(dma_rx_req),
  .dma_tx_req(dma_tx_req), .dma_ack(dma_ack), .rx_ready_flag(rx_ready_flag));
`default_nettype wire
